// ==== design/eeprom_defines.svh ====
// constants for the two-wire eeprom slave front end
// assumes a single 20 MHz system clock samples the serial pins
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

`define EE_TYPE_ARRAY     4'ha
`define EE_TYPE_IDPAGE    4'hb
`define EE_ARRAY_BYTES    2048
`define EE_PAGE_BYTES     16
`define EE_ADDR_BITS      11
`define EE_RW_BIT         0
`define EE_ID_LOCK_ABIT   7
`define EE_LOCK_DATA_BIT  1
`define EE_CLK_MHZ        20
`define EE_WRITE_TIME_US  5000

`endif

// ==== design/eeprom_pkg.sv ====
// types shared by the eeprom slave modules
// assumes nothing beyond a SystemVerilog compiler
package eeprom_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SELECT = 3'b001,
        ST_ADDR   = 3'b010,
        ST_WDATA  = 3'b011,
        ST_RDATA  = 3'b100,
        ST_WCYCLE = 3'b101
    } bus_state_t;

    typedef enum logic [1:0] {
        TGT_ARRAY  = 2'b00,
        TGT_IDPAGE = 2'b01,
        TGT_LOCK   = 2'b10
    } target_t;

endpackage

// ==== design/pin_sync.sv ====
// three-flop synchroniser for pins from outside the sys_clk domain
// assumes raw inputs are asynchronous; clean updates when stages 2 and 3 agree
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] clean
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    stage1[i] <= 1'b1;
                    stage2[i] <= 1'b1;
                    stage3[i] <= 1'b1;
                    clean[i]  <= 1'b1;
                end else begin
                    stage1[i] <= raw[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // filters single-sample glitches
                    if (stage2[i] == stage3[i]) begin
                        clean[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate

endmodule // pin_sync

// ==== design/byte_store.sv ====
// main byte array plus identification page and its lock flag
// assumes one write per cycle from the write-cycle sequencer
`timescale 1ns/1ps
`include "eeprom_defines.svh"

module byte_store (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     wrEn,
    input  wire logic                     wrId,
    input  wire logic [`EE_ADDR_BITS-1:0] wrAddr,
    input  wire logic [7:0]               wrData,
    input  wire logic                     lockSet,
    input  wire logic                     rdId,
    input  wire logic [`EE_ADDR_BITS-1:0] rdAddr,
    output logic      [7:0]               rdData,
    output logic                          idLocked
);

    // storage is not reset: it models cell contents, not control state
    logic [7:0] arrayMem [`EE_ARRAY_BYTES];
    logic [7:0] idMem    [`EE_PAGE_BYTES];

    always_ff @(posedge sys_clk) begin
        if (wrEn && !wrId) begin
            arrayMem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wrEn && wrId && !idLocked) begin
            idMem[wrAddr[3:0]] <= wrData;
        end
    end

    // volatile stand-in for the permanent lock fuse
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            idLocked <= 1'b0;
        end else if (lockSet) begin
            idLocked <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= rdId ? idMem[rdAddr[3:0]] : arrayMem[rdAddr];
        end
    end

endmodule // byte_store

// ==== design/eeprom_serial_slave.sv ====
// two-wire slave front end of a 16-Kbit eeprom with a lockable id page
// assumes scl, sda and write protect are asynchronous pins sampled by sys_clk
`timescale 1ns/1ps
`include "eeprom_defines.svh"

module eeprom_serial_slave
    import eeprom_pkg::*;
#(
    parameter int WRITE_TIME_US = `EE_WRITE_TIME_US
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    input  wire logic write_protect_in,
    output logic      busy,
    output logic      idLocked
);

    import eeprom_pkg::*;

    localparam int WRITE_CYCLES = WRITE_TIME_US * `EE_CLK_MHZ;

    // ---------------------------------------------------------------
    // pin sampling and bus conditions
    // ---------------------------------------------------------------
    logic sclS;
    logic sdaS;
    logic wpS;
    logic sclQ;
    logic sdaQ;

    // the lines are pulled up outside, so a released pin samples high
    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .raw     ({sclIn, sdaIn, write_protect_in}),
        .clean   ({sclS, sdaS, wpS})
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end else begin
            sclQ <= sclS;
            sdaQ <= sdaS;
        end
    end

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    assign sclRise   = sclS & ~sclQ;
    assign sclFall   = ~sclS & sclQ;
    assign startSeen = sclS & sclQ & sdaQ & ~sdaS;
    assign stopSeen  = sclS & sclQ & ~sdaQ & sdaS;

    // ---------------------------------------------------------------
    // state and decode
    // ---------------------------------------------------------------
    bus_state_t state;
    target_t    target;
    logic [3:0] bitCnt;
    logic       inAck;
    logic [7:0] shiftIn;
    logic [7:0] txShift;
    logic       masterNack;
    logic [`EE_ADDR_BITS-1:0] ptr;
    logic [3:0] idPtr;
    logic [7:0] pageBuf [`EE_PAGE_BYTES];
    logic [`EE_PAGE_BYTES-1:0] pageMask;
    logic       lockReq;
    logic [31:0] wcCount;
    logic [4:0] commitIdx;
    logic [7:0] rdByte;

    logic typeArray;
    logic typeId;
    logic byteDone;
    logic rdByteDone;
    logic ackGive;
    logic commitOk;
    logic wcDone;

    assign typeArray  = shiftIn[7:4] == `EE_TYPE_ARRAY;
    assign typeId     = shiftIn[7:4] == `EE_TYPE_IDPAGE;
    assign byteDone   = sclFall & ~inAck & (bitCnt == 4'h8);
    assign rdByteDone = byteDone & (state == ST_RDATA);
    // the stop's own scl rise counts as a bit, so the slot right after
    // a data ack holds exactly one counted bit
    assign commitOk   = (state == ST_WDATA) & (bitCnt == 4'h1) & ~inAck
                        & ((|pageMask) | lockReq);
    assign wcDone     = (wcCount >= 32'(WRITE_CYCLES - 1)) & commitIdx[4];
    assign busy       = state == ST_WCYCLE;
    assign sdaOut     = 1'b0;

    always_comb begin
        ackGive = 1'b0;
        case (state)
            ST_SELECT: ackGive = typeArray | typeId;
            ST_ADDR:   ackGive = 1'b1;
            ST_WDATA:  ackGive = (target == TGT_ARRAY) ? ~wpS
                                                        : ~wpS & ~idLocked;
            default:   ackGive = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // bus sequencer
    // ---------------------------------------------------------------
    // sdaOe only ever follows scl edges of the master: no clock or
    // start/stop is generated here
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            bitCnt     <= 4'h0;
            inAck      <= 1'b0;
            shiftIn    <= 8'h00;
            txShift    <= 8'h00;
            sdaOe      <= 1'b0;
            masterNack <= 1'b0;
        end else if (state == ST_WCYCLE) begin
            sdaOe <= 1'b0;
            if (wcDone) begin
                state <= ST_IDLE;
            end
        end else if (startSeen) begin
            state  <= ST_SELECT;
            bitCnt <= 4'h0;
            inAck  <= 1'b0;
            sdaOe  <= 1'b0;
        end else if (stopSeen) begin
            state  <= commitOk ? ST_WCYCLE : ST_IDLE;
            bitCnt <= 4'h0;
            inAck  <= 1'b0;
            sdaOe  <= 1'b0;
        end else if (state != ST_IDLE) begin
            if (sclRise && !inAck && bitCnt != 4'h8) begin
                bitCnt  <= bitCnt + 4'h1;
                shiftIn <= {shiftIn[6:0], sdaS};
            end
            if (sclRise && inAck && state == ST_RDATA) begin
                masterNack <= sdaS;
            end
            if (byteDone) begin
                inAck <= 1'b1;
                if (state == ST_SELECT && !ackGive) begin
                    state <= ST_IDLE;
                    sdaOe <= 1'b0;
                end else begin
                    sdaOe <= (state == ST_RDATA) ? 1'b0 : ackGive;
                end
            end else if (sclFall && inAck) begin
                inAck  <= 1'b0;
                bitCnt <= 4'h0;
                sdaOe  <= 1'b0;
                case (state)
                    ST_SELECT: begin
                        if (shiftIn[`EE_RW_BIT]) begin
                            state   <= ST_RDATA;
                            sdaOe   <= ~rdByte[7];
                            txShift <= {rdByte[6:0], 1'b0};
                        end else begin
                            state <= ST_ADDR;
                        end
                    end
                    ST_ADDR: state <= ST_WDATA;
                    ST_RDATA: begin
                        if (masterNack) begin
                            state <= ST_IDLE;
                        end else begin
                            sdaOe   <= ~rdByte[7];
                            txShift <= {rdByte[6:0], 1'b0};
                        end
                    end
                    default: state <= state;
                endcase
            end else if (sclFall && state == ST_RDATA && bitCnt != 4'h0) begin
                sdaOe   <= ~txShift[7];
                txShift <= {txShift[6:0], 1'b0};
            end
        end
    end

    // ---------------------------------------------------------------
    // address pointers and target
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            target <= TGT_ARRAY;
            ptr    <= '0;
            idPtr  <= 4'h0;
        end else if (byteDone && state == ST_SELECT && ackGive) begin
            target <= typeId ? TGT_IDPAGE : TGT_ARRAY;
            if (typeArray) begin
                ptr[10:8] <= shiftIn[3:1];
            end
        end else if (byteDone && state == ST_ADDR) begin
            if (target == TGT_ARRAY) begin
                ptr[7:0] <= shiftIn;
            end else if (shiftIn[`EE_ID_LOCK_ABIT]) begin
                target <= TGT_LOCK;
            end else begin
                idPtr <= shiftIn[3:0];
            end
        end else if (byteDone && state == ST_WDATA && ackGive) begin
            if (target == TGT_ARRAY) begin
                ptr[3:0] <= ptr[3:0] + 4'h1; // page roll-over
            end else if (target == TGT_IDPAGE) begin
                idPtr <= idPtr + 4'h1;
            end
        end else if (rdByteDone) begin
            if (target == TGT_ARRAY) begin
                ptr <= ptr + 11'h001;
            end else begin
                idPtr <= idPtr + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // page buffer, filled by acked data bytes, drained by the write cycle
    // ---------------------------------------------------------------
    // buffering lets a stop in the wrong slot discard the whole write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pageMask <= '0;
            lockReq  <= 1'b0;
        end else if (state == ST_WCYCLE) begin
            if (wcDone) begin
                pageMask <= '0;
                lockReq  <= 1'b0;
            end
        end else if (startSeen || (stopSeen && !commitOk)) begin
            pageMask <= '0;
            lockReq  <= 1'b0;
        end else if (byteDone && state == ST_WDATA && ackGive) begin
            if (target == TGT_LOCK) begin
                lockReq <= lockReq | shiftIn[`EE_LOCK_DATA_BIT];
            end else if (target == TGT_ARRAY) begin
                pageBuf[ptr[3:0]]  <= shiftIn;
                pageMask[ptr[3:0]] <= 1'b1;
            end else begin
                pageBuf[idPtr]  <= shiftIn;
                pageMask[idPtr] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // internal write cycle timer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state != ST_WCYCLE) begin
            wcCount   <= 32'h0;
            commitIdx <= 5'h00;
        end else begin
            wcCount <= wcCount + 32'h1;
            if (!commitIdx[4]) begin
                commitIdx <= commitIdx + 5'h01;
            end
        end
    end

    logic       wrEn;
    logic       wrId;
    logic       lockSet;
    logic [`EE_ADDR_BITS-1:0] wrAddr;
    logic [`EE_ADDR_BITS-1:0] rdAddr;

    assign wrEn    = busy & ~commitIdx[4] & pageMask[commitIdx[3:0]] & ~wpS;
    assign wrId    = target == TGT_IDPAGE;
    assign lockSet = busy & lockReq & (commitIdx == 5'h00) & ~wpS;
    assign wrAddr  = wrId ? {7'h00, commitIdx[3:0]} : {ptr[10:4], commitIdx[3:0]};
    assign rdAddr  = (target == TGT_ARRAY) ? ptr : {7'h00, idPtr};

    byte_store u_store (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wrEn     (wrEn),
        .wrId     (wrId),
        .wrAddr   (wrAddr),
        .wrData   (pageBuf[commitIdx[3:0]]),
        .lockSet  (lockSet),
        .rdId     (target != TGT_ARRAY),
        .rdAddr   (rdAddr),
        .rdData   (rdByte),
        .idLocked (idLocked)
    );

endmodule // eeprom_serial_slave

// ==== verification/eeprom_serial_slave_monitor.sv ====
// concurrent checks on the pins of the two-wire eeprom slave
// assumes it is bound to the slave top with the same write time parameter
`timescale 1ns/1ps
`include "eeprom_defines.svh"

module eeprom_serial_slave_monitor #(
    parameter int WRITE_TIME_US = `EE_WRITE_TIME_US
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic write_protect_in,
    input wire logic busy,
    input wire logic idLocked
);
    localparam int BUSY_CYCLES = WRITE_TIME_US * `EE_CLK_MHZ;
    int busyCount;

    // counts how many edges busy has been seen high in the current write cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !busy) begin
            busyCount <= 0;
        end else begin
            busyCount <= busyCount + 1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_busy_quiet: assert property (busy |-> !sdaOe)
        else $error("data line driven during write cycle");
    a_drain_only: assert property (sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
    a_edge_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data line changed while serial clock high");
    a_ack_stands: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("low bit released too early");
    a_commit_stop: assert property ($rose(busy) |-> sclIn && sdaIn)
        else $error("write cycle began without a stop");
    a_wp_blocks: assert property ($rose(busy) |-> !write_protect_in)
        else $error("write cycle began while protected");
    a_busy_length: assert property ($fell(busy) |-> busyCount == BUSY_CYCLES)
        else $error("write cycle length wrong");
    a_lock_sticky: assert property (idLocked |=> idLocked)
        else $error("lock flag cleared");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !sdaOe && !busy && !idLocked)
        else $error("outputs active after reset");

    c_write: cover property ($fell(busy));
    c_lock: cover property ($rose(idLocked));
    c_drive: cover property ($rose(sdaOe));
endmodule // eeprom_serial_slave_monitor

bind eeprom_serial_slave eeprom_serial_slave_monitor #(
    .WRITE_TIME_US(WRITE_TIME_US)
) i_monitor (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .write_protect_in(write_protect_in),
    .busy(busy),
    .idLocked(idLocked)
);

// ==== verification/serial_master_model.sv ====
// two-wire bus master model driving the serial clock and pulling data low
// assumes the data line is pulled up and steps are timed by the system clock
`timescale 1ns/1ps

module serial_master_model (
    input  wire logic sysClk,
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaLow
);
    // 12 clocks a half period: 600 ns, far above the four-clock delay of the pin synchroniser
    localparam int HALF = 12;

    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sysClk);
        #2;
    endtask

    task automatic start_cond();
        sdaLow = 1'b0;
        tick(HALF);
        sclOut = 1'b1;
        tick(HALF);
        sdaLow = 1'b1;
        tick(HALF);
        sclOut = 1'b0;
        tick(3);
    endtask

    task automatic stop_cond();
        sdaLow = 1'b1;
        tick(HALF);
        sclOut = 1'b1;
        tick(HALF);
        sdaLow = 1'b0;
        tick(HALF);
    endtask

    task automatic xfer_bit(input logic b, output logic s);
        sdaLow = ~b;
        tick(HALF - 3);
        sclOut = 1'b1;
        tick(HALF / 2);
        s = sdaLine;
        tick(HALF / 2);
        sclOut = 1'b0;
        tick(3);
    endtask

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(v[i], s);
        xfer_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ackIt, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, v[i]);
        xfer_bit(~ackIt, s);
    endtask
endmodule // serial_master_model

// ==== verification/tb.sv ====
// self-checking bench for the two-wire eeprom slave front end
// assumes the master model owns the pins and the data line is pulled up
`timescale 1ns/1ps

module tb;
    logic sysClk = 1'b0;
    logic sysRst = 1'b1;
    logic writeProtect = 1'b0;
    logic sclPin;
    logic masterLow;
    logic sdaWire;
    logic sdaOut;
    logic sdaOe;
    logic busy;
    logic idLocked;
    int   mismatches = 0;
    int   cmpCount = 0;
    int   cycles = 0;

    always #25 sysClk = ~sysClk;
    // wired-and of both open-drain drivers over the pull-up
    assign sdaWire = ~masterLow & ~(sdaOe & ~sdaOut);

    eeprom_serial_slave #(.WRITE_TIME_US(20)) i_dut (
        .sys_clk(sysClk),
        .sys_rst(sysRst),
        .sclIn(sclPin),
        .sdaIn(sdaWire),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .write_protect_in(writeProtect),
        .busy(busy),
        .idLocked(idLocked)
    );

    serial_master_model i_master (
        .sysClk(sysClk),
        .sdaLine(sdaWire),
        .sclOut(sclPin),
        .sdaLow(masterLow)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmpCount++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // an unknown expectation means the write cycle is only waited for
    task automatic wait_idle(input logic expBusy);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 500; n++) begin
            i_master.tick(1);
            if (busy === 1'b1) seen = 1'b1;
            if (seen && busy === 1'b0) break;
        end
        if (expBusy !== 1'bx) chk("write cycle", {7'h0, expBusy}, {7'h0, seen});
    endtask

    task automatic wr(input logic [7:0] sel, input logic [7:0] adr, input logic [7:0] d0,
                      input logic [7:0] d1, input int n, input logic dAck, input logic commit);
        logic a;
        i_master.start_cond();
        i_master.send_byte(sel, a);
        chk("select ack", 8'h1, {7'h0, a});
        i_master.send_byte(adr, a);
        chk("address ack", 8'h1, {7'h0, a});
        if (n > 0) i_master.send_byte(d0, a);
        if (n > 0) chk("data ack", {7'h0, dAck}, {7'h0, a});
        if (n > 1) i_master.send_byte(d1, a);
        if (n > 1) chk("data ack", {7'h0, dAck}, {7'h0, a});
        i_master.stop_cond();
        wait_idle(commit);
    endtask

    task automatic rd(input logic [7:0] sel, input logic [7:0] adr, input logic [7:0] exp);
        logic a;
        logic [7:0] q;
        i_master.start_cond();
        i_master.send_byte(sel & 8'hfe, a);
        i_master.send_byte(adr, a);
        i_master.start_cond();
        i_master.send_byte(sel | 8'h01, a);
        chk("read select ack", 8'h1, {7'h0, a});
        i_master.recv_byte(1'b0, q);
        i_master.stop_cond();
        chk("read byte", exp, q);
    endtask

    task automatic t_array();
        wr(8'ha0, 8'h3c, 8'h11, 8'h00, 1, 1'b1, 1'b1);
        wr(8'haa, 8'h3c, 8'ha5, 8'h5a, 2, 1'b1, 1'b1);
        rd(8'haa, 8'h3c, 8'ha5);
        rd(8'haa, 8'h3d, 8'h5a);
        rd(8'ha0, 8'h3c, 8'h11);
    endtask

    task automatic t_rollover();
        wr(8'ha2, 8'h1f, 8'hc3, 8'h3c, 2, 1'b1, 1'b1);
        rd(8'ha2, 8'h10, 8'h3c);
        rd(8'ha2, 8'h1f, 8'hc3);
    endtask

    task automatic t_protect();
        writeProtect = 1'b1;
        wr(8'haa, 8'h3c, 8'hff, 8'h00, 2, 1'b0, 1'b0);
        writeProtect = 1'b0;
        rd(8'haa, 8'h3c, 8'ha5);
    endtask

    task automatic t_select();
        logic a;
        for (int i = 0; i < 2; i++) begin
            i_master.start_cond();
            i_master.send_byte(i ? 8'h90 : 8'hd0, a);
            chk("foreign select ack", 8'h0, {7'h0, a});
            i_master.stop_cond();
        end
        wr(8'haa, 8'h3c, 8'h00, 8'h00, 0, 1'b1, 1'b0);
        rd(8'haa, 8'h3c, 8'ha5);
    endtask

    task automatic t_busy();
        logic a;
        i_master.start_cond();
        i_master.send_byte(8'ha4, a);
        i_master.send_byte(8'h40, a);
        i_master.send_byte(8'h9c, a);
        i_master.stop_cond();
        i_master.start_cond();
        i_master.send_byte(8'ha4, a);
        chk("select while busy", 8'h0, {7'h0, a});
        i_master.stop_cond();
        wait_idle(1'b1);
        rd(8'ha4, 8'h40, 8'h9c);
    endtask

    task automatic t_idpage();
        wr(8'hbe, 8'h35, 8'h77, 8'h88, 2, 1'b1, 1'b1);
        rd(8'hb0, 8'h05, 8'h77);
        rd(8'hb6, 8'h76, 8'h88);
    endtask

    task automatic t_lock();
        chk("lock flag", 8'h0, {7'h0, idLocked});
        wr(8'hb0, 8'h80, 8'h02, 8'h00, 1, 1'b1, 1'b1);
        chk("lock flag", 8'h1, {7'h0, idLocked});
        wr(8'hb0, 8'h05, 8'h00, 8'h00, 1, 1'b0, 1'bx);
        rd(8'hb0, 8'h05, 8'h77);
    endtask

    // about 22000 cycles expected; the ceiling leaves well over twice that
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge sysClk);
        #2 sysRst = 1'b0;
        i_master.tick(6);
        chk("idle after reset", 8'h0, {5'h0, sdaOe, busy, idLocked});
        t_array();
        t_rollover();
        t_protect();
        t_select();
        t_busy();
        t_idpage();
        t_lock();
        report_and_stop();
    end
endmodule // tb
